/* lps_ctrl_map.svh */
// register offsets, field positions, reset values and timing of the light/proximity controller
`ifndef LPS_CTRL_MAP_SVH
`define LPS_CTRL_MAP_SVH
// byte addresses of the register words
`define LPS_A_CTRL 8'h00
`define LPS_A_ATIME 8'h04
`define LPS_A_WTIME 8'h08
`define LPS_A_PPULSE 8'h0c
`define LPS_A_LED 8'h10
`define LPS_A_PERS 8'h14
`define LPS_A_ALSTH 8'h18
`define LPS_A_PRXTH 8'h1c
`define LPS_A_ALSDATA 8'h20
`define LPS_A_PRXDATA 8'h24
`define LPS_A_STATUS 8'h28
`define LPS_A_INTCLR 8'h2c
`define LPS_A_INTEN 8'h30
// field positions
`define LPS_F_PON 0
`define LPS_F_PEN 1
`define LPS_F_AEN 2
`define LPS_F_WEN 3
`define LPS_F_WLONG 8
`define LPS_F_ST_ALS 0
`define LPS_F_ST_PRX 1
// reset values
`define LPS_R_PPULSE 8'h01
`define LPS_R_TH 32'hffff0000
// arbitrary neutral bus address of the two-wire slave
`define LPS_I2C_ADDR 7'h2a
// timing
`define LPS_CLK_NS 50
`define LPS_STEP_NS 2720000
`define LPS_PULSE_NS 16000
`define LPS_LONG_MULT 12
`endif

/* lps_pkg.sv */
// types of the light/proximity controller
package lps_pkg;
   // measurement sequencer states
   typedef enum logic [3:0] {
      SQ_IDLE = 4'h1,
      SQ_PROX = 4'h2,
      SQ_ALS = 4'h4,
      SQ_WAIT = 4'h8
   } lps_seq_type;
   // two-wire slave states
   typedef enum logic [5:0] {
      IS_IDLE = 6'h01,
      IS_ADDR = 6'h02,
      IS_ACK = 6'h04,
      IS_WDAT = 6'h08,
      IS_RDAT = 6'h10,
      IS_RACK = 6'h20
   } lps_i2c_type;
endpackage

/* lps_ctrl.sv */
// light/proximity sensor controller: sequencer, persistence, interrupt, two-wire and AXI4-Lite
`timescale 1ns/1ps
`include "lps_ctrl_map.svh"

// persistence filter for one measurement type
module lps_persist (
   input wire logic clock,
   input wire logic rst,
   input wire logic eval,
   input wire logic [15:0] val,
   input wire logic [31:0] th,
   input wire logic [3:0] pers,
   output logic hit
);
   logic [3:0] cnt_q; // consecutive violations, saturating
   wire viol = (val < th[15:0]) | (val > th[31:16]);
   wire [4:0] cnt_inc = {1'b0, cnt_q} + 5'h01;
   assign hit = eval & viol & (cnt_inc >= {1'b0, pers});
   // a result inside the window restarts the count
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_q <= 4'h0;
      end else if (eval) begin
         if (!viol) begin
            cnt_q <= 4'h0;
         end else if (cnt_q != 4'hf) begin
            cnt_q <= cnt_inc[3:0];
         end
      end
   end
endmodule

// Function
// - two light channels integrate together, 16-bit
// - results copied to data registers at end
// - host link is two-wire bus, 400 kHz
// - interrupt holds until firmware clears it
// - interrupt only when enabled and threshold met
// - event when result leaves upper/lower window
// - event after programmed consecutive violations
// - separate thresholds, persistence per measurement
// - LED current selectable among four levels
// - LED pulses per measurement 1 to 255
// - each LED pulse period is 16 us
// - wait timer 2.72 ms to over 8 s
// - low-power wait state between measurements
// - interrupt pin open drain, active low
// - LED sink open drain, only during pulses
module lps_ctrl #(
   parameter int unsigned STEP_CYC = `LPS_STEP_NS / `LPS_CLK_NS
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic visible_ir_channel,
   input wire logic infrared_channel,
   input wire logic prox_detect,
   output logic led_sink_output,
   output logic led_sink_oe_n,
   output logic [1:0] led_drive_sel,
   output logic int_pin_out,
   output logic int_pin_oe_n
);
   localparam logic [8:0] PULSE_CYC = 9'(`LPS_PULSE_NS / `LPS_CLK_NS);
   localparam logic [8:0] PULSE_ON = 9'(`LPS_PULSE_NS / `LPS_CLK_NS / 2);
   localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);

   // software registers
   logic [3:0] ctrl_q; // power, prox, ambient, wait enables
   logic [7:0] atime_q; // integration steps minus one
   logic [8:0] wtime_q; // wait steps minus one, long bit
   logic [7:0] ppulse_q; // LED pulses per measurement
   logic [1:0] led_q; // LED current level
   logic [7:0] pers_q; // ambient [3:0], proximity [7:4]
   logic [31:0] als_th_q; // hi:lo thresholds
   logic [31:0] prx_th_q;
   logic [31:0] als_data_q; // infrared:visible_ir results
   logic [15:0] prx_data_q;
   logic [1:0] st_q; // sticky event flags
   logic [1:0] int_en_q;
   lps_pkg::lps_seq_type sq_q, sq_d; // sequencer stage, also read back in status

   // input synchronisers: {prox, ir, vis, sda, scl}
   logic [4:0] s1_q, s2_q, s3_q;
   always_ff @(posedge clock) begin
      s1_q <= {prox_detect, infrared_channel, visible_ir_channel, sda_in, scl_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
   end
   wire [4:0] rise = s2_q & ~s3_q; // edge finders use stages two and three only

   // read mux shared by the AXI read, the two-wire read and the write merge
   function automatic logic [31:0] rd_word(input logic [7:0] a);
      case (a)
         `LPS_A_CTRL: rd_word = {28'h0, ctrl_q};
         `LPS_A_ATIME: rd_word = {24'h0, atime_q};
         `LPS_A_WTIME: rd_word = {23'h0, wtime_q};
         `LPS_A_PPULSE: rd_word = {24'h0, ppulse_q};
         `LPS_A_LED: rd_word = {30'h0, led_q};
         `LPS_A_PERS: rd_word = {24'h0, pers_q};
         `LPS_A_ALSTH: rd_word = als_th_q;
         `LPS_A_PRXTH: rd_word = prx_th_q;
         `LPS_A_ALSDATA: rd_word = als_data_q;
         `LPS_A_PRXDATA: rd_word = {16'h0, prx_data_q};
         `LPS_A_STATUS: rd_word = {24'h0, sq_q, 2'h0, st_q};
         `LPS_A_INTEN: rd_word = {30'h0, int_en_q};
         default: rd_word = 32'h0; // clear register and holes read zero
      endcase
   endfunction
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= `LPS_A_INTEN);
   endfunction

   // two-wire slave (SCL sampled by the core clock)
   lps_pkg::lps_i2c_type ist_q;
   logic [7:0] isr_q; // shift register
   logic [3:0] icnt_q; // bit count
   logic irw_q; // read transaction
   logic [7:0] iptr_q; // byte pointer into the map
   logic iptr_set_q; // pointer byte received
   logic sda_oe_n_q;
   wire scl = s2_q[0];
   wire sda = s2_q[1];
   wire scl_rise = rise[0];
   wire scl_fall = ~s2_q[0] & s3_q[0];
   wire i_start = scl & s3_q[0] & s3_q[1] & ~sda;
   wire i_stop = scl & s3_q[0] & ~s3_q[1] & sda;
   wire i_byte = scl_fall & (icnt_q == 4'h8);
   wire i2c_wr = (ist_q == lps_pkg::IS_WDAT) & i_byte & iptr_set_q;
   logic [31:0] i_word; // driven by the mux process below
   wire [7:0] i_rd = i_word[{iptr_q[1:0], 3'h0} +: 8];

   // common write port: a two-wire byte write stalls the AXI write
   logic aw_rdy_q, w_rdy_q, bvalid_q, ar_rdy_q, rvalid_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q, w_mask_q;
   wire ax_wr = ~aw_rdy_q & ~w_rdy_q & ~bvalid_q & ~i2c_wr;
   wire wr_go = ax_wr | i2c_wr;
   wire [7:0] wr_addr = i2c_wr ? {iptr_q[7:2], 2'h0} : aw_addr_q;
   wire [31:0] wr_mask = i2c_wr ? (32'h000000ff << {iptr_q[1:0], 3'h0}) : w_mask_q;
   wire [31:0] wr_data = i2c_wr ? {4{isr_q}} : w_data_q;
   logic [31:0] wr_val;
   // a process wakes on every register the mux reads, an assign would not
   always_comb begin
      i_word = rd_word({iptr_q[7:2], 2'h0});
      wr_val = (rd_word(wr_addr) & ~wr_mask) | (wr_data & wr_mask);
   end
   wire [31:0] strb_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
      {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

   // two-wire slave state machine
   always_ff @(posedge clock) begin
      if (rst) begin
         ist_q <= lps_pkg::IS_IDLE;
         isr_q <= 8'h00;
         icnt_q <= 4'h0;
         irw_q <= 1'b0;
         iptr_q <= 8'h00;
         iptr_set_q <= 1'b0;
         sda_oe_n_q <= 1'b1;
      end else if (i_start) begin
         ist_q <= lps_pkg::IS_ADDR; // repeated start also lands here
         icnt_q <= 4'h0;
         sda_oe_n_q <= 1'b1;
      end else if (i_stop) begin
         ist_q <= lps_pkg::IS_IDLE;
         sda_oe_n_q <= 1'b1;
      end else begin
         unique case (ist_q)
            lps_pkg::IS_IDLE: begin
            end
            lps_pkg::IS_ADDR, lps_pkg::IS_WDAT: begin
               if (scl_rise) begin
                  isr_q <= {isr_q[6:0], sda};
                  icnt_q <= icnt_q + 4'h1;
               end else if (i_byte && ist_q == lps_pkg::IS_ADDR) begin
                  if (isr_q[7:1] == `LPS_I2C_ADDR) begin
                     sda_oe_n_q <= 1'b0; // acknowledge address
                     irw_q <= isr_q[0];
                     iptr_set_q <= iptr_set_q & isr_q[0];
                     ist_q <= lps_pkg::IS_ACK;
                  end else begin
                     ist_q <= lps_pkg::IS_IDLE; // not ours: wait for next start
                  end
               end else if (i_byte) begin
                  sda_oe_n_q <= 1'b0;
                  ist_q <= lps_pkg::IS_ACK;
                  iptr_set_q <= 1'b1;
                  iptr_q <= iptr_set_q ? iptr_q + 8'h01 : isr_q;
               end
            end
            lps_pkg::IS_ACK, lps_pkg::IS_RACK: begin
               if (ist_q == lps_pkg::IS_RACK && scl_rise && sda) begin
                  ist_q <= lps_pkg::IS_IDLE; // master nack ends the read
               end else if (scl_fall && (irw_q || ist_q == lps_pkg::IS_RACK)) begin
                  sda_oe_n_q <= i_rd[7]; // released means a one
                  isr_q <= {i_rd[6:0], 1'b0};
                  icnt_q <= 4'h1;
                  iptr_q <= iptr_q + 8'h01;
                  ist_q <= lps_pkg::IS_RDAT;
               end else if (scl_fall) begin
                  sda_oe_n_q <= 1'b1;
                  icnt_q <= 4'h0;
                  ist_q <= lps_pkg::IS_WDAT;
               end
            end
            lps_pkg::IS_RDAT: begin
               if (i_byte) begin
                  sda_oe_n_q <= 1'b1; // let the master acknowledge
                  ist_q <= lps_pkg::IS_RACK;
               end else if (scl_fall) begin
                  sda_oe_n_q <= isr_q[7];
                  isr_q <= {isr_q[6:0], 1'b0};
                  icnt_q <= icnt_q + 4'h1;
               end
            end
            default: ist_q <= lps_pkg::IS_IDLE;
         endcase
      end
   end

   // AXI write channel: hold address and data, answer after the merge
   always_ff @(posedge clock) begin
      if (rst) begin
         aw_rdy_q <= 1'b1;
         w_rdy_q <= 1'b1;
         bvalid_q <= 1'b0;
         s_axi_bresp <= 2'h0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0;
         w_mask_q <= 32'h0;
      end else begin
         if (s_axi_awvalid && aw_rdy_q) begin
            aw_addr_q <= s_axi_awaddr;
            aw_rdy_q <= 1'b0;
         end
         if (s_axi_wvalid && w_rdy_q) begin
            w_data_q <= s_axi_wdata;
            w_mask_q <= strb_mask;
            w_rdy_q <= 1'b0;
         end
         if (ax_wr) begin
            bvalid_q <= 1'b1;
            s_axi_bresp <= mapped(aw_addr_q) ? 2'h0 : 2'h2; // slverr on a hole
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            aw_rdy_q <= 1'b1;
            w_rdy_q <= 1'b1;
         end
      end
   end

   // AXI read channel: data one cycle after the address
   always_ff @(posedge clock) begin
      if (rst) begin
         ar_rdy_q <= 1'b1;
         rvalid_q <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && ar_rdy_q) begin
         ar_rdy_q <= 1'b0;
         rvalid_q <= 1'b1;
         s_axi_rdata <= rd_word(s_axi_araddr);
         s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
         ar_rdy_q <= 1'b1;
      end
   end
   assign s_axi_awready = aw_rdy_q;
   assign s_axi_wready = w_rdy_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_arready = ar_rdy_q;
   assign s_axi_rvalid = rvalid_q;

   // configuration registers
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_q <= 4'h0;
         atime_q <= 8'h00;
         wtime_q <= 9'h000;
         ppulse_q <= `LPS_R_PPULSE;
         led_q <= 2'h0;
         pers_q <= 8'h00;
         als_th_q <= `LPS_R_TH;
         prx_th_q <= `LPS_R_TH;
         int_en_q <= 2'h0;
      end else if (wr_go) begin
         if (wr_addr == `LPS_A_CTRL) ctrl_q <= wr_val[3:0];
         if (wr_addr == `LPS_A_ATIME) atime_q <= wr_val[7:0];
         if (wr_addr == `LPS_A_WTIME) wtime_q <= wr_val[8:0];
         if (wr_addr == `LPS_A_PPULSE) ppulse_q <= wr_val[7:0];
         if (wr_addr == `LPS_A_LED) led_q <= wr_val[1:0];
         if (wr_addr == `LPS_A_PERS) pers_q <= wr_val[7:0];
         if (wr_addr == `LPS_A_ALSTH) als_th_q <= wr_val;
         if (wr_addr == `LPS_A_PRXTH) prx_th_q <= wr_val;
         if (wr_addr == `LPS_A_INTEN) int_en_q <= wr_val[1:0];
      end
   end

   // measurement sequencer
   logic [15:0] tick_q; // step or pulse timer
   logic [11:0] steps_q; // steps or pulses completed
   logic [15:0] vis_acc_q, ir_acc_q, prx_acc_q;
   wire pon = ctrl_q[`LPS_F_PON];
   wire prox_go = ctrl_q[`LPS_F_PEN] & (ppulse_q != 8'h00);
   wire [11:0] wait_base = {4'h0, wtime_q[7:0]} + 12'h001;
   wire [11:0] wait_total = wtime_q[`LPS_F_WLONG] ? 12'(wait_base * `LPS_LONG_MULT) : wait_base;
   wire step_done = (sq_q != lps_pkg::SQ_PROX) & (tick_q == STEP_LAST);
   wire pulse_done = tick_q == {7'h0, PULSE_CYC - 9'h001};
   wire led_on = (sq_q == lps_pkg::SQ_PROX) & (tick_q < {7'h0, PULSE_ON});
   wire prox_end = (sq_q == lps_pkg::SQ_PROX) & pulse_done
      & (steps_q == {4'h0, ppulse_q - 8'h01});
   wire als_end = (sq_q == lps_pkg::SQ_ALS) & step_done & (steps_q == {4'h0, atime_q});
   wire wait_end = (sq_q == lps_pkg::SQ_WAIT) & step_done & (steps_q == wait_total - 12'h001);
   wire stage_end = prox_end | als_end | wait_end;
   wire [15:0] tick_inc = tick_q + 16'h0001;
   wire [15:0] vis_inc = vis_acc_q + 16'h0001;
   wire [15:0] ir_inc = ir_acc_q + 16'h0001;
   wire [15:0] prx_inc = prx_acc_q + 16'h0001;
   lps_pkg::lps_seq_type first_st, after_als, after_prox;
   assign first_st = prox_go ? lps_pkg::SQ_PROX : ctrl_q[`LPS_F_AEN] ? lps_pkg::SQ_ALS
      : ctrl_q[`LPS_F_WEN] ? lps_pkg::SQ_WAIT : lps_pkg::SQ_IDLE;
   assign after_als = ctrl_q[`LPS_F_WEN] ? lps_pkg::SQ_WAIT : first_st;
   assign after_prox = ctrl_q[`LPS_F_AEN] ? lps_pkg::SQ_ALS : after_als;

   // next stage; clearing power aborts at once
   always_comb begin
      sq_d = sq_q;
      if (!pon) begin
         sq_d = lps_pkg::SQ_IDLE;
      end else begin
         unique case (sq_q)
            lps_pkg::SQ_IDLE: sq_d = first_st;
            lps_pkg::SQ_PROX: if (prox_end) sq_d = after_prox;
            lps_pkg::SQ_ALS: if (als_end) sq_d = after_als;
            lps_pkg::SQ_WAIT: if (wait_end) sq_d = first_st;
            default: sq_d = lps_pkg::SQ_IDLE;
         endcase
      end
   end

   // timers and accumulators restart at every stage end
   always_ff @(posedge clock) begin
      if (rst || !pon || stage_end || sq_q == lps_pkg::SQ_IDLE) begin
         sq_q <= rst ? lps_pkg::SQ_IDLE : sq_d;
         tick_q <= 16'h0;
         steps_q <= 12'h0;
         vis_acc_q <= 16'h0;
         ir_acc_q <= 16'h0;
         prx_acc_q <= 16'h0;
      end else begin
         sq_q <= sq_d;
         if (step_done || (sq_q == lps_pkg::SQ_PROX && pulse_done)) begin
            tick_q <= 16'h0;
            steps_q <= steps_q + 12'h001;
         end else begin
            tick_q <= tick_inc;
         end
         // both channels count at once, saturating at 16 bits
         if (sq_q == lps_pkg::SQ_ALS && rise[2] && vis_acc_q != 16'hffff) begin
            vis_acc_q <= vis_inc;
         end
         if (sq_q == lps_pkg::SQ_ALS && rise[3] && ir_acc_q != 16'hffff) begin
            ir_acc_q <= ir_inc;
         end
         if (led_on && rise[4] && prx_acc_q != 16'hffff) begin
            prx_acc_q <= prx_inc;
         end
      end
   end

   // results become visible only when a conversion completes
   always_ff @(posedge clock) begin
      if (rst) begin
         als_data_q <= 32'h0;
         prx_data_q <= 16'h0;
      end else begin
         if (als_end) als_data_q <= {ir_acc_q, vis_acc_q};
         if (prox_end) prx_data_q <= prx_acc_q;
      end
   end

   // independent persistence filters per measurement type
   logic als_hit, prx_hit;
   lps_persist u_als_pers (
      .clock(clock),
      .rst(rst),
      .eval(als_end),
      .val(vis_acc_q),
      .th(als_th_q),
      .pers(pers_q[3:0]),
      .hit(als_hit)
   );
   lps_persist u_prx_pers (
      .clock(clock),
      .rst(rst),
      .eval(prox_end),
      .val(prx_acc_q),
      .th(prx_th_q),
      .pers(pers_q[7:4]),
      .hit(prx_hit)
   );

   // sticky flags: a new event wins over a same-cycle clear
   wire clr_go = wr_go & (wr_addr == `LPS_A_INTCLR);
   wire [1:0] clr_bits = clr_go ? (wr_data[1:0] & wr_mask[1:0]) : 2'h0;
   wire [1:0] set_bits = {prx_hit, als_hit};
   wire [1:0] st_d = (st_q & ~clr_bits) | set_bits;
   wire irq_d = |(st_d & int_en_q);
   always_ff @(posedge clock) begin
      if (rst) begin
         st_q <= 2'h0;
         irq <= 1'b0;
         int_pin_oe_n <= 1'b1;
      end else begin
         st_q <= st_d;
         irq <= irq_d;
         int_pin_oe_n <= ~irq_d;
      end
   end

   // pin drivers: open-drain outputs always drive zero when enabled
   always_ff @(posedge clock) begin
      if (rst) begin
         led_sink_oe_n <= 1'b1;
         led_drive_sel <= 2'h0;
      end else begin
         led_sink_oe_n <= ~led_on;
         led_drive_sel <= led_q;
      end
   end
   always_ff @(posedge clock) begin
      sda_out <= 1'b0;
      led_sink_output <= 1'b0;
      int_pin_out <= 1'b0;
   end
   assign sda_oe_n = sda_oe_n_q;
endmodule

/* lps_ctrl_properties.sv */
// port checker of the light/proximity controller
`timescale 1ns/1ps
module lps_ctrl_checker #(
   parameter int unsigned STEP_CYC = 20
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq,
   input wire logic sda_out,
   input wire logic led_sink_output,
   input wire logic led_sink_oe_n,
   input wire logic int_pin_out,
   input wire logic int_pin_oe_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [8:0] on_q; // cycles the led sink has been on so far
   logic [8:0] on_d;
   // restarts whenever the sink lets go, so one count covers one on-half
   assign on_d = led_sink_oe_n ? 9'h000 : on_q + 9'h001;
   always_ff @(posedge clock) begin
      on_q <= rst ? 9'h000 : on_d;
   end
   AST_INT_PIN: assert property (int_pin_oe_n == !irq)
      else $error("int pin differs from irq");
   AST_OD_LOW: assert property (!int_pin_out && !led_sink_output && !sda_out)
      else $error("open drain data not low");
   AST_LED_ON: assert property (!led_sink_oe_n |-> on_q < 9'h0a0)
      else $error("led on too long");
   AST_LED_HALF: assert property ($rose(led_sink_oe_n) |-> on_q == 9'h0a0)
      else $error("led on half not 160 cycles");
   // only a bus write may drop the interrupt
   AST_IRQ_HOLD: assert property ($fell(irq) |-> !s_axi_awready
      || !$past(s_axi_awready) || !$past(s_axi_awready, 2))
      else $error("irq dropped without a write");
   AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer late");
   AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read not closed");
   cover property ($rose(irq));
   cover property ($rose(led_sink_oe_n));
   cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind lps_ctrl lps_ctrl_checker #(.STEP_CYC(STEP_CYC)) lps_ctrl_checker_i (.*);

/* lps_i2c_host.sv */
// behavioural two-wire host driving the link clock and the data line
`timescale 1ns/1ps
`include "lps_ctrl_map.svh"
module lps_i2c_host (
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   localparam int QTR = 100; // a quarter of the 400 ns link clock period
   // idle: clock stands high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // data set while clock low, line sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      #QTR scl = 1'b1;
      #QTR r = sda;
      #QTR scl = 1'b0;
      #QTR;
   endtask
   // eight bits msb first, then the acknowledge bit
   task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx, output logic a);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ak, a);
   endtask
   // odd offset keeps the link edges off the core clock edges
   task automatic start();
      #7 sda_low = 1'b1;
      #(2*QTR) scl = 1'b0;
      #QTR;
   endtask
   task automatic stop();
      sda_low = 1'b1;
      #QTR scl = 1'b1;
      #(2*QTR) sda_low = 1'b0;
      #(2*QTR);
   endtask
   // address, pointer, one data byte; nk holds the three acknowledge bits
   task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
      output logic [2:0] nk);
      logic [7:0] x;
      start();
      xfer({dev, 1'b0}, 1'b1, x, nk[2]);
      xfer(p, 1'b1, x, nk[1]);
      xfer(d, 1'b1, x, nk[0]);
      stop();
   endtask
   // set the pointer, then read one byte and refuse more
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      logic [2:0] n;
      start();
      xfer({`LPS_I2C_ADDR, 1'b0}, 1'b1, d, n[0]);
      xfer(p, 1'b1, d, n[1]);
      stop();
      start();
      xfer({`LPS_I2C_ADDR, 1'b1}, 1'b1, d, n[2]);
      xfer(8'hff, 1'b1, d, n[0]);
      stop();
   endtask
endmodule

/* test_lps_ctrl.sv */
// self-checking bench of the light/proximity controller
`timescale 1ns/1ps
`include "lps_ctrl_map.svh"
module test_lps_ctrl;
   logic clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
   logic scl_in, sda_in, sda_out, sda_oe_n, led_sink_output, led_sink_oe_n, m_low;
   logic int_pin_out, int_pin_oe_n, visible_ir_channel, infrared_channel, prox_detect;
   logic [7:0] s_axi_awaddr, s_axi_araddr, rb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [2:0] nk;
   logic [1:0] s_axi_bresp, s_axi_rresp, led_drive_sel, pdiv, resp;
   int mismatches, compares, pulses;
   // all light inputs share one train, so both channel counts must agree
   assign visible_ir_channel = pdiv[1];
   assign infrared_channel = pdiv[1];
   assign prox_detect = pdiv[1];
   // pull-up on the data line: low when either party pulls
   assign sda_in = !(m_low || !sda_oe_n);
   lps_ctrl #(.STEP_CYC(20)) lps_ctrl_i (.*);
   lps_i2c_host lps_i2c_host_i (.scl(scl_in), .sda_low(m_low), .sda(sda_in));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) pdiv <= pdiv + 2'h1;
   // each fall of the sink enable starts one led pulse
   always @(negedge led_sink_oe_n) pulses++;
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // address and data offered together, each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(negedge clock); // let the write's effects land before anyone looks
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // the run needs about 3200 cycles; a hang beyond twelve times that is cut
   initial begin
      repeat (40000) @(posedge clock);
      mismatches++;
      print_verdict();
   end
   initial begin
      {mismatches, compares, pulses} = '0;
      {rst, pdiv, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {3'h4, 48'h0};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_wstrb = 4'hf;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      axi_rd(`LPS_A_PPULSE, rd, resp);
      chk("ppulse_reset", rd, 32'(`LPS_R_PPULSE));
      axi_rd(`LPS_A_PRXTH, rd, resp);
      chk("prox_th_reset", rd, `LPS_R_TH);
      axi_rd(8'h40, rd, resp);
      chk("unmapped_rresp", 32'(resp), 32'h2);
      axi_wr(8'h44, 32'h1, resp);
      chk("unmapped_bresp", 32'(resp), 32'h2);
      $display("test reset_map done");
      for (int k = 0; k < 4; k++) begin
         axi_wr(`LPS_A_LED, 32'(k), resp);
         chk("led_level", 32'(led_drive_sel), 32'(k));
      end
      $display("test led_levels done");
      lps_i2c_host_i.wr(`LPS_I2C_ADDR, `LPS_A_LED, 8'h02, nk);
      chk("link_write_ack", 32'(nk), 32'h0);
      lps_i2c_host_i.wr(7'h15, `LPS_A_LED, 8'h01, nk);
      chk("foreign_addr_nack", 32'(nk), 32'h7);
      chk("led_by_link", 32'(led_drive_sel), 32'h2);
      lps_i2c_host_i.rd(`LPS_A_LED, rb);
      chk("link_read", 32'(rb), 32'h2);
      $display("test link done");
      // ambient upper bound 5, two violations in a row, three pulses a cycle
      axi_wr(`LPS_A_PPULSE, 32'h3, resp);
      axi_wr(`LPS_A_ATIME, 32'h1, resp);
      axi_wr(`LPS_A_ALSTH, 32'h00050000, resp);
      axi_wr(`LPS_A_PERS, 32'h2, resp);
      axi_wr(`LPS_A_INTEN, 32'h3, resp);
      pulses = 0;
      axi_wr(`LPS_A_CTRL, 32'hf, resp);
      wait (irq === 1'b1);
      chk("cycles_to_irq", 32'(pulses / 3), 32'h2);
      // power off only in an off-half, so no pulse is cut short
      wait (led_sink_oe_n === 1'b0);
      @(posedge led_sink_oe_n);
      axi_wr(`LPS_A_CTRL, 32'h0, resp);
      axi_rd(`LPS_A_ALSDATA, rd, resp);
      chk("channels_equal", 32'(rd[15:0]), 32'(rd[31:16]));
      chk("ambient_above", 32'(rd[15:0] > 16'h0005), 32'h1);
      axi_rd(`LPS_A_STATUS, rd, resp);
      chk("ambient_event_only", 32'(rd[1:0]), 32'h1);
      repeat (40) @(posedge clock);
      chk("irq_held", 32'(irq), 32'h1);
      chk("int_pin_low", 32'(int_pin_oe_n), 32'h0);
      axi_wr(`LPS_A_INTEN, 32'h0, resp);
      chk("irq_masked", 32'(irq), 32'h0);
      axi_wr(`LPS_A_INTEN, 32'h3, resp);
      chk("irq_unmasked", 32'(irq), 32'h1);
      axi_wr(`LPS_A_INTCLR, 32'h3, resp);
      chk("irq_cleared", 32'(irq), 32'h0);
      chk("int_pin_released", 32'(int_pin_oe_n), 32'h1);
      $display("test measure_irq done");
      print_verdict();
   end
endmodule
